// ==== pkg/spcr_consts.svh ====
// Constants of the serial CRC register access port
`ifndef SPCR_CONSTS_SVH
`define SPCR_CONSTS_SVH

// ----------------------------------------------------------------
// Frame geometry, counter limits and CRC polynomial
// ----------------------------------------------------------------
`define SPCR_FIRST_WORD_BITS 6'd32
`define SPCR_BURST_WORD_BITS 6'd24
`define SPCR_CNT_MAX 6'h3F
`define SPCR_WORDS_MAX 8'hFF
`define SPCR_SEEK_MAX 7'h7F
`define SPCR_CRC_POLY 8'h07

// ----------------------------------------------------------------
// Addresses
// ----------------------------------------------------------------
`define SPCR_READ_SEL_ADDR 8'h64
`define SPCR_ALERT_STAT_ADDR 8'h3E
`define SPCR_MODEM_RX_ADDR 7'h58

// ----------------------------------------------------------------
// Read select data field and alert status layout
// ----------------------------------------------------------------
`define SPCR_RSEL_PTR_LSB 0
`define SPCR_RSEL_PTR_MSB 6
`define SPCR_RSEL_AUTO_BIT 8
`define SPCR_RSEL_INFO_BIT 9
`define SPCR_RSEL_PTR_RST 7'h00
`define SPCR_SPI_ERR_BIT 4

`endif

// ==== pkg/spcr_pkg.sv ====
// Types shared by the serial CRC register access port
package spcr_pkg;

  typedef logic [7:0] spcr_addr_t;
  typedef logic [15:0] spcr_data_t;
  typedef logic [31:0] spcr_word_t;

  // What the end of a frame does
  typedef enum logic [1:0] {
    SPCR_END_NONE,
    SPCR_END_WRITE,
    SPCR_END_BURST,
    SPCR_END_ERROR
  } spcr_end_t;

endpackage : spcr_pkg

// ==== design/spcr_port.sv ====
// Serial CRC protected register access port, subordinate side
//
// How it works
// - incoming frame shifts in, MSB first
// - input data sampled on serial clock fall
// - second frame shifts selected register out
// - output bit 31 is one from select
// - remaining output bits change on clock rise
// - register contents in output bits 23..8
// - bits 30..24 address or status flags
// - readback word ends with its CRC
// - auto readback outputs pointer every frame
// - burst steps address, sends data plus CRC
// - burst valid only for 32+24n rises
// - write needs exactly 32 falling edges
// - bad length discarded, error flag latched
// - burst skips registers deselected in mask
// - burst from modem receive never advances
// - no register writes while bursting
// - CRC polynomial x8+x2+x+1 over 24 bits
// - good CRC commits the write
// - bad CRC discards, latches error, alert
// - writing one clears latched flag
`timescale 1ns/1ps
`include "spcr_consts.svh"

module spcr_port #(
  parameter logic [6:0] MODEM_RX_ADDR = `SPCR_MODEM_RX_ADDR,
  parameter logic [7:0] ALERT_STAT_ADDR = `SPCR_ALERT_STAT_ADDR
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_sdi,
  output logic o_sdo,
  output logic o_sdo_oe_n,
  output logic [7:0] o_rd_addr,
  input wire logic [15:0] i_rd_data,
  input wire logic i_rd_in_burst,
  output logic o_reg_wr,
  output logic [7:0] o_reg_addr,
  output logic [15:0] o_reg_wdata,
  input wire logic i_spi_err_mask,
  input wire logic i_other_alert,
  input wire logic i_adc_rdy,
  input wire logic i_modem_alert_flag,
  input wire logic i_din_comp,
  output logic o_alert_n,
  output logic o_spi_err_flag,
  output logic o_auto_rd_en,
  output logic o_read_return_info_sel,
  output logic [6:0] o_readback_ptr
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // CRC-8 over 24 bits
  function automatic logic [7:0] spcr_crc8(input logic [23:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 23; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ (((c[7] ^ d[i]) == 1'b1) ? `SPCR_CRC_POLY : 8'h00);
    end
    return c;
  endfunction : spcr_crc8

  // word with leading one and trailing CRC
  function automatic spcr_pkg::spcr_word_t spcr_word(input logic [6:0] info,
                                                      input logic [15:0] d);
    return {1'b1, info, d, spcr_crc8({1'b1, info, d})};
  endfunction : spcr_word

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] sclk_sync_reg;
  logic [2:0] cs_sync_reg;
  logic [1:0] sdi_sync_reg;

  // Link clock is slow (800 ns), so sampling it with the core clock is safe
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sclk_sync_reg <= 3'h0;
      cs_sync_reg <= 3'h7;
      sdi_sync_reg <= 2'h0;
    end else begin
      sclk_sync_reg <= {sclk_sync_reg[1:0], i_sclk};
      cs_sync_reg <= {cs_sync_reg[1:0], i_cs_n};
      sdi_sync_reg <= {sdi_sync_reg[0], i_sdi};
    end
  end

  wire frame_start = ~cs_sync_reg[1] & cs_sync_reg[2];
  wire frame_end = cs_sync_reg[1] & ~cs_sync_reg[2];
  wire active = ~cs_sync_reg[1] & ~cs_sync_reg[2];
  wire sclk_fall = active & ~sclk_sync_reg[1] & sclk_sync_reg[2];
  wire sclk_rise = active & sclk_sync_reg[1] & ~sclk_sync_reg[2];

  // ----------------------------------------------------------------
  // Receive path
  // ----------------------------------------------------------------
  spcr_pkg::spcr_word_t in_shift_reg;
  logic [5:0] fall_cnt_reg;

  wire [31:0] in_shift_next = {in_shift_reg[30:0], sdi_sync_reg[1]};
  wire [5:0] fall_cnt_inc = (fall_cnt_reg == `SPCR_CNT_MAX) ? fall_cnt_reg
                                                              : fall_cnt_reg + 6'd1;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      in_shift_reg <= 32'h0000_0000;
      fall_cnt_reg <= 6'h00;
    end else if (frame_start) begin
      fall_cnt_reg <= 6'h00;
    end else if (sclk_fall) begin
      in_shift_reg <= in_shift_next;
      fall_cnt_reg <= fall_cnt_inc;
    end
  end

  // ----------------------------------------------------------------
  // Read select state and word counting
  // ----------------------------------------------------------------
  logic [6:0] ptr_reg;
  logic auto_reg;
  logic info_reg;
  logic rd_pending_reg;
  logic rd_active_reg;
  logic [5:0] rise_in_word_reg;
  logic [7:0] words_reg;

  wire [5:0] word_limit = (words_reg == 8'h00) ? `SPCR_FIRST_WORD_BITS
                                               : `SPCR_BURST_WORD_BITS;
  wire [5:0] rise_inc = rise_in_word_reg + 6'd1;
  wire word_done = sclk_rise & (rise_inc == word_limit);
  wire [7:0] words_inc = (words_reg == `SPCR_WORDS_MAX) ? words_reg : words_reg + 8'd1;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rise_in_word_reg <= 6'h00;
      words_reg <= 8'h00;
    end else if (frame_start) begin
      rise_in_word_reg <= 6'h00;
      words_reg <= 8'h00;
    end else if (word_done) begin
      rise_in_word_reg <= 6'h00;
      words_reg <= words_inc;
    end else if (sclk_rise) begin
      rise_in_word_reg <= rise_inc;
    end
  end

  // ----------------------------------------------------------------
  // Readback address and burst stepping
  // ----------------------------------------------------------------
  logic [6:0] rd_addr_reg;
  logic hold_reg;
  logic seek_reg;
  logic [6:0] seek_cnt_reg;

  wire [6:0] rd_addr_inc = rd_addr_reg + 7'd1;
  // modem receive start pins the address
  wire hold_start = (ptr_reg == MODEM_RX_ADDR);
  // step at a word's first rise, so the next word is ready at its end
  wire step_now = sclk_rise & (rise_in_word_reg == 6'h00) & rd_active_reg & ~hold_reg;
  // skip deselected ones; the seek must end within one word of clocks
  wire seek_step = seek_reg & ~i_rd_in_burst & (seek_cnt_reg != `SPCR_SEEK_MAX);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rd_addr_reg <= `SPCR_RSEL_PTR_RST;
      hold_reg <= 1'b0;
      seek_reg <= 1'b0;
      seek_cnt_reg <= 7'h00;
    end else if (cs_sync_reg[2]) begin
      rd_addr_reg <= ptr_reg;
      hold_reg <= hold_start;
      seek_reg <= 1'b0;
    end else if (step_now) begin
      rd_addr_reg <= rd_addr_inc;
      seek_reg <= 1'b1;
      seek_cnt_reg <= 7'h00;
    end else if (seek_step) begin
      rd_addr_reg <= rd_addr_inc;
      seek_cnt_reg <= seek_cnt_reg + 7'd1;
    end else begin
      seek_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Transmit path
  // ----------------------------------------------------------------
  spcr_pkg::spcr_word_t out_shift_reg;
  logic oe_n_reg;
  logic alert_n_reg;

  // auto readback reads on every frame
  wire rd_now = rd_pending_reg | auto_reg;
  // return info selects address or flags
  wire [6:0] status_info = {~alert_n_reg, i_adc_rdy, i_modem_alert_flag, 1'b0,
                            i_din_comp, 2'b00};
  wire [6:0] ret_info = info_reg ? status_info : rd_addr_reg;
  // bit 31 set as select falls
  wire [31:0] first_word = rd_now ? spcr_word(ret_info, i_rd_data) : 32'h0000_0000;
  wire [31:0] full_next = spcr_word(ret_info, i_rd_data);
  // further words carry data and CRC only
  wire [31:0] burst_word = {full_next[23:0], 8'h00};

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      out_shift_reg <= 32'h0000_0000;
      rd_active_reg <= 1'b0;
    end else if (frame_start) begin
      out_shift_reg <= first_word;
      rd_active_reg <= rd_now;
    end else if (word_done & rd_active_reg) begin
      out_shift_reg <= burst_word;
    end else if (sclk_rise) begin
      out_shift_reg <= {out_shift_reg[30:0], 1'b0};
    end
  end

  // Output is driven only while select is low
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      oe_n_reg <= 1'b1;
    end else begin
      oe_n_reg <= cs_sync_reg[1];
    end
  end

  assign o_sdo = out_shift_reg[31];
  assign o_sdo_oe_n = oe_n_reg;

  // ----------------------------------------------------------------
  // End of frame decision
  // ----------------------------------------------------------------
  wire [7:0] rx_addr = in_shift_reg[31:24];
  wire [15:0] rx_data = in_shift_reg[23:8];
  wire crc_ok = (spcr_crc8(in_shift_reg[31:8]) == in_shift_reg[7:0]);
  // burst ends on a whole word, at least two
  wire burst_ok = rd_active_reg & (words_reg >= 8'd2) & (rise_in_word_reg == 6'h00);
  wire len_ok = (fall_cnt_reg == `SPCR_FIRST_WORD_BITS);

  spcr_pkg::spcr_end_t end_kind;

  // everything is judged at select rise
  assign end_kind = !frame_end ? spcr_pkg::SPCR_END_NONE :
                    burst_ok ? spcr_pkg::SPCR_END_BURST :
                    (len_ok & crc_ok) ? spcr_pkg::SPCR_END_WRITE :
                    spcr_pkg::SPCR_END_ERROR;

  wire wr_now = (end_kind == spcr_pkg::SPCR_END_WRITE);
  wire sel_wr = wr_now & (rx_addr == `SPCR_READ_SEL_ADDR);
  // one in flag position clears it
  wire clr_wr = wr_now & (rx_addr == ALERT_STAT_ADDR) & rx_data[`SPCR_SPI_ERR_BIT];
  wire ext_wr = wr_now & ~sel_wr;

  // ----------------------------------------------------------------
  // Read select, readback request and write strobe
  // ----------------------------------------------------------------
  wire rd_pending_next = sel_wr ? 1'b1 :
                         (frame_end & rd_active_reg) ? 1'b0 : rd_pending_reg;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ptr_reg <= `SPCR_RSEL_PTR_RST;
      auto_reg <= 1'b0;
      info_reg <= 1'b0;
      rd_pending_reg <= 1'b0;
    end else begin
      rd_pending_reg <= rd_pending_next;
      if (sel_wr) begin
        ptr_reg <= rx_data[`SPCR_RSEL_PTR_MSB:`SPCR_RSEL_PTR_LSB];
        auto_reg <= rx_data[`SPCR_RSEL_AUTO_BIT];
        info_reg <= rx_data[`SPCR_RSEL_INFO_BIT];
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_reg_wr <= 1'b0;
      o_reg_addr <= 8'h00;
      o_reg_wdata <= 16'h0000;
    end else begin
      o_reg_wr <= ext_wr;
      if (ext_wr) begin
        o_reg_addr <= rx_addr;
        o_reg_wdata <= rx_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // Error flag, alert and outputs
  // ----------------------------------------------------------------
  logic err_reg;
  // set beats clear in the same cycle
  wire err_next = (end_kind == spcr_pkg::SPCR_END_ERROR) | (err_reg & ~clr_wr);
  // Mask only hides the flag from the pin; the flag itself stays latched
  wire alert_n_next = ~((err_reg & ~i_spi_err_mask) | i_other_alert);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      err_reg <= 1'b0;
      alert_n_reg <= 1'b1;
    end else begin
      err_reg <= err_next;
      alert_n_reg <= alert_n_next;
    end
  end

  assign o_rd_addr = {1'b0, rd_addr_reg};
  assign o_alert_n = alert_n_reg;
  assign o_spi_err_flag = err_reg;
  assign o_auto_rd_en = auto_reg;
  assign o_read_return_info_sel = info_reg;
  assign o_readback_ptr = ptr_reg;

endmodule : spcr_port

// ==== sim/spcr_port_assertions.sv ====
// Checker for the serial register access port
`timescale 1ns/1ps
module spcr_port_assertions #(
  parameter logic [7:0] ALERT_STAT_ADDR = 8'h3e
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_spi_err_mask,
  input wire logic i_other_alert,
  input wire logic o_sdo,
  input wire logic o_sdo_oe_n,
  input wire logic o_reg_wr,
  input wire logic [7:0] o_reg_addr,
  input wire logic [15:0] o_reg_wdata,
  input wire logic o_spi_err_flag,
  input wire logic o_alert_n,
  input wire logic o_auto_rd_en,
  input wire logic [6:0] o_readback_ptr
);
  // ------------------------------------------------
  // Checks
  // ------------------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  // Frame over: select high for two samples
  sequence s_end;
    $past(i_cs_n, 1) && $past(i_cs_n, 2);
  endsequence

  a_wr_at_end: assert property (o_reg_wr |-> s_end)
    else $error("write before frame end");
  a_wr_pulse: assert property (o_reg_wr |=> !o_reg_wr)
    else $error("write pulse too long");
  a_no_sel_out: assert property (o_reg_wr |-> o_reg_addr != 8'h64)
    else $error("read select passed out");
  a_err_no_wr: assert property ($rose(o_spi_err_flag) |-> s_end ##0 !o_reg_wr)
    else $error("error frame wrote");
  a_err_alert: assert property (o_spi_err_flag && !i_spi_err_mask |=> !o_alert_n)
    else $error("alert not shown");
  a_alert_idle: assert property (!o_spi_err_flag && !i_other_alert |=> o_alert_n)
    else $error("alert without cause");
  a_clr_by_wr: assert property ($fell(o_spi_err_flag) |->
    o_reg_wr && o_reg_addr == ALERT_STAT_ADDR && o_reg_wdata[4])
    else $error("flag cleared without write");
  a_bit31_one: assert property ($fell(o_sdo_oe_n) && o_auto_rd_en |-> o_sdo)
    else $error("first out bit not one");
  a_sdo_on_rise: assert property (
    !o_sdo_oe_n && $past(!o_sdo_oe_n) && $changed(o_sdo) |-> $past(i_sclk, 2))
    else $error("out bit moved without clock rise");
  a_ptr_at_end: assert property ($changed(o_readback_ptr) |-> s_end)
    else $error("pointer moved in frame");
endmodule : spcr_port_assertions

// ==== sim/spcr_host.sv ====
// Host serial main model driving the register access port
`timescale 1ns/1ps
module spcr_host (
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_sdi,
  input wire logic i_sdo
);
  // Clock stands low between frames
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_sdi = 1'b0;
  end

  function automatic logic [7:0] crc8(input logic [23:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 23; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    end
    return c;
  endfunction : crc8

  // select held low for n clocks
  // out bit taken before each rise
  task automatic xfer(input logic [7:0] a, input logic [15:0] d, input logic bad,
                      input int n, output logic [79:0] rx);
    logic [31:0] w;
    w = {a, d, crc8({a, d}) ^ {7'h00, bad}};
    rx = '0;
    // Pins move by non-blocking assignment: the core edge in this time step sees the old level
    o_cs_n <= 1'b0;
    #800;
    for (int i = 0; i < n; i++) begin
      rx = {rx[78:0], i_sdo};
      // Data set at rise, so it is stable well past the sampling fall
      o_sdi <= (i < 32) ? w[31 - i] : ~o_sdi;
      o_sclk <= 1'b1;
      #400;
      o_sclk <= 1'b0;
      #400;
    end
    o_cs_n <= 1'b1;
    o_sdi <= ~o_sdi;
    #1200;
  endtask : xfer
endmodule : spcr_host

// ==== sim/spcr_port_tb.sv ====
// Bench for the serial register access port
`timescale 1ns/1ps
module spcr_port_tb;
  logic i_clk, i_rst, i_sclk, i_cs_n, i_sdi, o_sdo, o_sdo_oe_n, i_rd_in_burst, o_reg_wr, sdo_pin;
  logic i_spi_err_mask, i_other_alert, i_adc_rdy, i_modem_alert_flag, i_din_comp, o_alert_n;
  logic o_spi_err_flag, o_auto_rd_en, o_read_return_info_sel;
  logic [6:0] o_readback_ptr;
  logic [7:0] o_rd_addr, o_reg_addr, wr_cnt;
  logic [15:0] i_rd_data, o_reg_wdata;
  logic [31:0] w;
  logic [79:0] rx;
  int errors = 0, cmp_count = 0, cycles = 0;

  spcr_port spcr_port_inst (.i_clk, .i_rst, .i_sclk, .i_cs_n, .i_sdi, .o_sdo, .o_sdo_oe_n,
    .o_rd_addr, .i_rd_data, .i_rd_in_burst, .o_reg_wr, .o_reg_addr, .o_reg_wdata,
    .i_spi_err_mask, .i_other_alert, .i_adc_rdy, .i_modem_alert_flag, .i_din_comp,
    .o_alert_n, .o_spi_err_flag, .o_auto_rd_en, .o_read_return_info_sel, .o_readback_ptr);
  spcr_host spcr_host_inst (.o_sclk(i_sclk), .o_cs_n(i_cs_n), .o_sdi(i_sdi), .i_sdo(sdo_pin));

  // Released out line shows the inverse, so a sample taken outside the drive window shows up
  assign sdo_pin = o_sdo_oe_n ? ~o_sdo : o_sdo;
  // Registers read back as address and its inverse; 0x11 left out of bursts
  assign i_rd_data = {o_rd_addr, ~o_rd_addr};
  assign i_rd_in_burst = (o_rd_addr != 8'h11);

  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  always @(posedge i_clk) wr_cnt <= i_rst ? 8'h00 : wr_cnt + {7'h00, o_reg_wr};
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 12000) begin
      errors++;
      results();
    end
  end

  function automatic logic [31:0] rbw(input logic [6:0] f, input logic [7:0] a);
    logic [23:0] h;
    h = {1'b1, f, a, ~a};
    return {h, spcr_host_inst.crc8(h)};
  endfunction : rbw

  task automatic chk(input string nm, input logic [79:0] got, input logic [79:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask : chk

  task automatic fr(input logic [7:0] a, input logic [15:0] d, input logic bad, input int n);
    spcr_host_inst.xfer(a, d, bad, n, rx);
  endtask : fr

  task automatic results();
    if (errors == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results

  initial begin
    i_rst = 1'b1;
    i_spi_err_mask = 1'b0;
    i_other_alert = 1'b0;
    i_adc_rdy = 1'b0;
    i_modem_alert_flag = 1'b0;
    i_din_comp = 1'b0;
    repeat (3) @(posedge i_clk);
    i_rst <= 1'b0;
    repeat (3) @(posedge i_clk);
    fr(8'h12, 16'hbeef, 1'b0, 32);
    chk("wr", {wr_cnt, o_reg_addr, o_reg_wdata}, {8'h01, 8'h12, 16'hbeef});
    fr(8'h13, 16'h0001, 1'b1, 32);
    chk("crc", {wr_cnt, o_spi_err_flag, o_alert_n}, {8'h01, 2'b10});
    @(posedge i_clk);
    i_spi_err_mask <= 1'b1;
    repeat (3) @(posedge i_clk);
    chk("mask", {o_spi_err_flag, o_alert_n}, 2'b11);
    i_spi_err_mask <= 1'b0;
    fr(8'h3e, 16'h0010, 1'b0, 32);
    chk("clr", {wr_cnt, o_spi_err_flag, o_alert_n}, {8'h02, 2'b01});
    fr(8'h14, 16'h0002, 1'b0, 31);
    chk("len", {wr_cnt, o_spi_err_flag}, {8'h02, 1'b1});
    fr(8'h3e, 16'hffff, 1'b0, 32);
    chk("all", {wr_cnt, o_spi_err_flag}, {8'h03, 1'b0});
    fr(8'h64, 16'h0010, 1'b0, 32);
    fr(8'h00, 16'h0000, 1'b0, 32);
    chk("rb", {wr_cnt, rx[31:0]}, {8'h04, rbw(7'h10, 8'h10)});
    @(posedge i_clk);
    i_adc_rdy <= 1'b1;
    i_din_comp <= 1'b1;
    fr(8'h64, 16'h0210, 1'b0, 32);
    chk("info", {o_read_return_info_sel, o_readback_ptr}, 8'h90);
    fr(8'h00, 16'h0000, 1'b0, 32);
    chk("rbi", rx[31:0], rbw(7'h24, 8'h10));
    fr(8'h64, 16'h0010, 1'b0, 32);
    fr(8'h00, 16'h0000, 1'b0, 80);
    chk("b1", rx[79:48], rbw(7'h10, 8'h10));
    w = rbw(7'h12, 8'h12);
    chk("b2", rx[47:24], w[23:0]);
    w = rbw(7'h13, 8'h13);
    chk("b3", rx[23:0], w[23:0]);
    chk("bnw", {wr_cnt, o_spi_err_flag}, {8'h05, 1'b0});
    fr(8'h64, 16'h0010, 1'b0, 32);
    fr(8'h00, 16'h0000, 1'b0, 61);
    chk("blen", {wr_cnt, o_spi_err_flag}, {8'h05, 1'b1});
    fr(8'h3e, 16'h0010, 1'b0, 32);
    fr(8'h64, 16'h0058, 1'b0, 32);
    fr(8'h00, 16'h0000, 1'b0, 80);
    w = rbw(7'h58, 8'h58);
    chk("m", {rx[47:24], rx[23:0]}, {w[23:0], w[23:0]});
    fr(8'h64, 16'h0120, 1'b0, 32);
    chk("auto", o_auto_rd_en, 1'b1);
    repeat (2) begin
      fr(8'h00, 16'h0000, 1'b0, 32);
      chk("ar", rx[31:0], rbw(7'h20, 8'h20));
    end
    chk("aw", wr_cnt, 8'h08);
    results();
  end
endmodule : spcr_port_tb

bind spcr_port spcr_port_assertions #(.ALERT_STAT_ADDR(ALERT_STAT_ADDR)) spcr_port_assertions_inst (
  .i_clk, .i_rst, .i_sclk, .i_cs_n, .i_spi_err_mask, .i_other_alert, .o_sdo, .o_sdo_oe_n,
  .o_reg_wr, .o_reg_addr, .o_reg_wdata, .o_spi_err_flag, .o_alert_n, .o_auto_rd_en,
  .o_readback_ptr);
